// File: verilog/cpm_cfg.svh
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

// register addresses, as seen by the register instructions
`define CPM_A_TSC 32'h0000_0010
`define CPM_A_CNT0 32'h0000_0020
`define CPM_A_CNT1 32'h0000_0021
`define CPM_A_SEL0 32'h0000_0028
`define CPM_A_SEL1 32'h0000_0029
`define CPM_A_UCTL 32'h0000_002C
`define CPM_A_OVST 32'h0000_002D
`define CPM_A_OVCL 32'h0000_002E
`define CPM_A_GEN 32'h0000_002F

// counter selectors of the read-counter instruction
`define CPM_PMC_SEL0 32'h0000_0000
`define CPM_PMC_SEL1 32'h0000_0001

// event select fields
`define CPM_SEL_EVT_LSB 0
`define CPM_SEL_EN 22
`define CPM_SEL_FLT_LSB 24

// user preference control fields
`define CPM_UCTL_PREF 0
`define CPM_UCTL_ALLOW 1

// reset values
`define CPM_RST_TSC 64'h0000_0000_0000_0000
`define CPM_RST_CNT 40'h00_0000_0000
`define CPM_RST_SEL 32'h0000_0000
`define CPM_RST_UCTL 2'h0
`define CPM_RST_GEN 2'h0

// cycles from an accepted request to its answer
`define CPM_RSP_LAT 3'h4

`endif

// File: verilog/cpm_pkg.sv
package cpm_pkg;

   // ************************************************
   // request kinds
   // ************************************************
   typedef enum logic [2:0] {
      OP_REG_RD,
      OP_REG_WR,
      OP_TS_RD,
      OP_CNT_RD,
      OP_UPREF
   } cpm_op_t;

   // one instruction handed over by the core
   typedef struct packed {
      cpm_op_t op;
      logic [1:0] thr;
      logic [1:0] cpl;
      logic mode64;
      logic [31:0] sel;
      logic [63:0] wdata;
   } cpm_req_t;

   // answer to one request
   typedef struct packed {
      logic fault;
      logic [63:0] data;
   } cpm_rsp_t;

   // event pulses from the core and the co-located units
   typedef struct packed {
      logic [7:0] core;
      logic [1:0] ctx;
      logic [7:0] ring;
      logic [7:0] tagdir;
      logic [7:0] cri;
   } cpm_evt_t;

endpackage : cpm_pkg

// File: verilog/cpm_sync.sv
`timescale 1ns/1ps

module cpm_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // pin and its rising edge
   input wire logic pin_i,
   output logic rise_o
);

   logic meta;
   logic stab;
   logic last;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= 1'b0;
         stab <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= pin_i;
         stab <= meta;
         last <= stab;
      end
   end

   // edge taken only from the settled copies
   assign rise_o = stab & ~last;

endmodule : cpm_sync

// File: verilog/cpm_ctr.sv
`timescale 1ns/1ps

`include "cpm_cfg.svh"

module cpm_ctr (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // load and count
   input wire logic we_i,
   input wire logic [39:0] wdata_i,
   input wire logic inc_i,
   // state
   output logic [39:0] cnt_o,
   output logic wrap_o
);

   // a load wins over a count in the same cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_o <= `CPM_RST_CNT;
      end else if (we_i) begin
         cnt_o <= wdata_i;
      end else if (inc_i) begin
         cnt_o <= cnt_o + 40'h00_0000_0001;
      end
   end

   // wrap past the top value, lost when a load overrides it
   assign wrap_o = inc_i & ~we_i & (&cnt_o);

endmodule : cpm_ctr

// File: verilog/cpm_core.sv
`timescale 1ns/1ps

`include "cpm_cfg.svh"

// Functional notes
// - one unit shared by four threads; counters and filters per thread.
// - counts all contexts by default; filter mask limits core events.
// - events come from core, ring stop, tag directory, core-ring link.
// - one 64-bit timestamp counter at 0x10, shared by all threads.
// - two 40-bit event counters at 0x20, 0x21, one copy per thread.
// - two 32-bit per-thread event selects at 0x28, 0x29, own enable.
// - per-thread control at 0x2C lets the preference gate counting.
// - overflow status at 0x2D is read-only, bits sticky on overflow.
// - writing ones to 0x2E clears matching status bits; zeros keep.
// - global enable at 0x2F permits counting; cleared bits stop it.
// - timestamp counter runs whatever the global enable holds.
// - counter read returns 40-bit value zero-extended; selector 0 or 1.
// - preference instruction sets or clears the bit from operand bit 0.
// - preference instruction cannot choose which counters it affects.
// - preference instruction only accepted in 64-bit mode.
// - register access at level 0 only; other instructions levels 0-3.
// - timestamp read completes within 4-5 cycles.
// - timestamp counters across the chip kept in step by a sync pin.
// - timestamp advances each core clock, never rescaled.
module cpm_core
   import cpm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // instruction requests
   input wire logic req_valid_i,
   input wire cpm_req_t req_i,
   output logic req_ready_o,
   // answers
   output logic rsp_valid_o,
   output cpm_rsp_t rsp_o,
   // events and timestamp sync pin
   input wire cpm_evt_t evt_i,
   input wire logic tsc_sync_i,
   // overflow status, bit 2*thread+counter
   output logic [7:0] ovf_o
);

   // ************************************************
   // state
   // ************************************************
   logic [63:0] timestamp_counter;
   logic [31:0] sel [0:3][0:1];
   logic [1:0] uctl [0:3];
   logic [1:0] gen [0:3];
   logic [39:0] cnt [0:3][0:1];
   logic [7:0] inc;
   logic [7:0] wrap;
   logic [7:0] cnt_we;
   logic [7:0] ovf_clr;
   logic [2:0] lat;
   logic sync_rise;
   logic tsc_ld;

   // ************************************************
   // helpers
   // ************************************************

   // addresses that answer to register instructions
   function automatic logic cpm_mapped(input logic [31:0] a);
      logic m;
      unique case (a)
         `CPM_A_TSC, `CPM_A_CNT0, `CPM_A_CNT1,
         `CPM_A_SEL0, `CPM_A_SEL1, `CPM_A_UCTL,
         `CPM_A_OVST, `CPM_A_OVCL, `CPM_A_GEN: m = 1'b1;
         default: m = 1'b0;
      endcase
      return m;
   endfunction : cpm_mapped

   // selected event line, filtered by context for core events
   function automatic logic cpm_hit(input logic [31:0] s,
                                    input cpm_evt_t e);
      logic [4:0] idx;
      logic [3:0] flt;
      logic h;
      idx = s[`CPM_SEL_EVT_LSB +: 5];
      flt = s[`CPM_SEL_FLT_LSB +: 4];
      case (idx[4:3])
         2'h0: h = e.core[idx[2:0]] &
                   ((flt == 4'h0) | flt[e.ctx]);
         2'h1: h = e.ring[idx[2:0]];
         2'h2: h = e.tagdir[idx[2:0]];
         2'h3: h = e.cri[idx[2:0]];
      endcase
      return h;
   endfunction : cpm_hit

   // ************************************************
   // request decode
   // ************************************************
   logic acc;
   logic is_reg;
   logic next_fault;
   logic [63:0] next_data;
   logic wr_ok;
   logic upref_ok;
   logic [2:0] b0;
   logic [2:0] b1;

   assign acc = req_valid_i & req_ready_o;
   assign is_reg = (req_i.op == OP_REG_RD) | (req_i.op == OP_REG_WR);
   assign b0 = {req_i.thr, 1'b0};
   assign b1 = {req_i.thr, 1'b1};

   // faults: privilege, unmapped address, mode, bad selector
   always_comb begin
      next_fault = 1'b0;
      if (is_reg) begin
         next_fault = (req_i.cpl != 2'h0)
                      | !cpm_mapped(req_i.sel);
      end
      if (req_i.op == OP_UPREF) begin
         next_fault = !req_i.mode64;
      end
      if (req_i.op == OP_CNT_RD) begin
         next_fault = (req_i.sel != `CPM_PMC_SEL0) &
                      (req_i.sel != `CPM_PMC_SEL1);
      end
   end

   assign wr_ok = acc & (req_i.op == OP_REG_WR) & !next_fault;
   assign upref_ok = acc & (req_i.op == OP_UPREF) & !next_fault;

   // read data; write-only and unmapped read as zero
   always_comb begin
      next_data = 64'h0000_0000_0000_0000;
      unique case (req_i.op)
         OP_TS_RD: next_data = timestamp_counter;
         OP_CNT_RD: begin
            // zero-extend the 40-bit count
            next_data = {24'h00_0000, cnt[req_i.thr][req_i.sel[0]]};
         end
         OP_REG_RD: begin
            case (req_i.sel)
               `CPM_A_TSC: next_data = timestamp_counter;
               `CPM_A_CNT0: next_data[39:0] = cnt[req_i.thr][0];
               `CPM_A_CNT1: next_data[39:0] = cnt[req_i.thr][1];
               `CPM_A_SEL0: next_data[31:0] = sel[req_i.thr][0];
               `CPM_A_SEL1: next_data[31:0] = sel[req_i.thr][1];
               `CPM_A_UCTL: next_data[1:0] = uctl[req_i.thr];
               `CPM_A_OVST: next_data[1:0] = {ovf_o[b1], ovf_o[b0]};
               `CPM_A_GEN: next_data[1:0] = gen[req_i.thr];
               default: next_data = 64'h0000_0000_0000_0000;
            endcase
         end
         OP_REG_WR, OP_UPREF: next_data = 64'h0000_0000_0000_0000;
         default: next_data = 64'h0000_0000_0000_0000;
      endcase
   end

   // ************************************************
   // answer pipeline
   // ************************************************

   // every request answers a fixed 4 cycles after it is taken;
   // one outstanding at a time keeps the answer order trivial
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_ready_o <= 1'b1;
         rsp_valid_o <= 1'b0;
         rsp_o <= '0;
         lat <= 3'h0;
      end else begin
         rsp_valid_o <= 1'b0;
         if (acc) begin
            req_ready_o <= 1'b0;
            lat <= `CPM_RSP_LAT - 3'h1;
            rsp_o <= {next_fault, next_data};
         end else if (!req_ready_o) begin
            lat <= lat - 3'h1;
            if (lat == 3'h1) begin
               rsp_valid_o <= 1'b1;
               req_ready_o <= 1'b1;
            end
         end
      end
   end

   // ************************************************
   // timestamp counter
   // ************************************************

   // sync pin is asynchronous to the core clock
   cpm_sync u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(tsc_sync_i),
      .rise_o(sync_rise)
   );

   assign tsc_ld = sync_rise | (wr_ok & (req_i.sel == `CPM_A_TSC));

   // one copy per core, ticks every clock, ignores the global enable;
   // a sync edge restarts every core from zero together
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timestamp_counter <= `CPM_RST_TSC;
      end else if (sync_rise) begin
         timestamp_counter <= `CPM_RST_TSC;
      end else if (tsc_ld) begin
         timestamp_counter <= req_i.wdata;
      end else begin
         timestamp_counter <= timestamp_counter + 64'h0000_0000_0000_0001;
      end
   end

   // ************************************************
   // configuration registers
   // ************************************************

   // event selects, one pair per thread
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int t = 0; t < 4; t++) begin
            sel[t][0] <= `CPM_RST_SEL;
            sel[t][1] <= `CPM_RST_SEL;
         end
      end else if (wr_ok) begin
         if (req_i.sel == `CPM_A_SEL0) begin
            sel[req_i.thr][0] <= req_i.wdata[31:0];
         end
         if (req_i.sel == `CPM_A_SEL1) begin
            sel[req_i.thr][1] <= req_i.wdata[31:0];
         end
      end
   end

   // global enable, bit per counter
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int t = 0; t < 4; t++) begin
            gen[t] <= `CPM_RST_GEN;
         end
      end else if (wr_ok && req_i.sel == `CPM_A_GEN) begin
         gen[req_i.thr] <= req_i.wdata[1:0];
      end
   end

   // preference control; the instruction only moves the one
   // preference bit, never picks counters
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int t = 0; t < 4; t++) begin
            uctl[t] <= `CPM_RST_UCTL;
         end
      end else if (wr_ok && req_i.sel == `CPM_A_UCTL) begin
         uctl[req_i.thr] <= req_i.wdata[1:0];
      end else if (upref_ok) begin
         uctl[req_i.thr][`CPM_UCTL_PREF] <= req_i.wdata[0];
      end
   end

   // ************************************************
   // event counters, two per thread
   // ************************************************
   for (genvar t = 0; t < 4; t++) begin : g_thr
      for (genvar c = 0; c < 2; c++) begin : g_ctr
         localparam int I = t * 2 + c;
         localparam logic [31:0] A = c ? `CPM_A_CNT1 : `CPM_A_CNT0;

         // both enables, then the preference when it is allowed
         assign inc[I] = gen[t][c] & sel[t][c][`CPM_SEL_EN] &
                         (~uctl[t][`CPM_UCTL_ALLOW] |
                          uctl[t][`CPM_UCTL_PREF]) &
                         cpm_hit(sel[t][c], evt_i);

         assign cnt_we[I] = wr_ok & (req_i.thr == t) & (req_i.sel == A);

         // write-one clear of this status bit
         assign ovf_clr[I] = wr_ok & (req_i.thr == t) &
                             (req_i.sel == `CPM_A_OVCL) &
                             req_i.wdata[c];

         cpm_ctr u_ctr (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .we_i(cnt_we[I]),
            .wdata_i(req_i.wdata[39:0]),
            .inc_i(inc[I]),
            .cnt_o(cnt[t][c]),
            .wrap_o(wrap[I])
         );
      end
   end

   // ************************************************
   // overflow status
   // ************************************************

   // sticky; a wrap in the clearing cycle wins, so none is lost
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ovf_o <= 8'h00;
      end else begin
         ovf_o <= wrap | (ovf_o & ~ovf_clr);
      end
   end

   // ************************************************
   // checks
   // ************************************************

   chk_tsc_free:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !tsc_ld |=> timestamp_counter == $past(timestamp_counter) + 64'h0000_0000_0000_0001)
      else $error("timestamp did not advance");

   chk_ts_latency:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      acc && req_i.op == OP_TS_RD |=>
      !rsp_valid_o [*3] ##1 rsp_valid_o &&
      rsp_o.data == $past(timestamp_counter, 4))
      else $error("timestamp read answer late or wrong");

   chk_reg_priv:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      acc && is_reg && req_i.cpl != 2'h0 |->
      ##4 rsp_valid_o && rsp_o.fault)
      else $error("register access above level 0 not refused");

   chk_upref_mode:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      acc && req_i.op == OP_UPREF |->
      ##4 rsp_valid_o && rsp_o.fault == !$past(req_i.mode64, 4))
      else $error("preference mode check wrong");

   chk_upref_set:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      upref_ok && req_i.thr == 2'h0 |=>
      uctl[0][`CPM_UCTL_PREF] == $past(req_i.wdata[0]))
      else $error("preference bit not taken");

   chk_ovf_hold:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ovf_o[1] && !ovf_clr[1] |=> ovf_o[1])
      else $error("overflow status dropped");

   chk_ovf_clear:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ovf_clr[1] && !wrap[1] |=> !ovf_o[1])
      else $error("overflow status not cleared");

   chk_gen_gate:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !gen[0][0] && !cnt_we[0] |=> cnt[0][0] == $past(cnt[0][0]))
      else $error("counter moved while disabled");

   chk_cnt_wrap:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wrap[1] |=> ovf_o[1] && cnt[0][1] == `CPM_RST_CNT)
      else $error("wrap did not flag overflow");

   chk_pmc_zext:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      acc && req_i.op == OP_CNT_RD && !next_fault |->
      ##4 rsp_valid_o && rsp_o.data[63:40] == 24'h00_0000)
      else $error("counter read not zero-extended");

endmodule : cpm_core

// File: sim/tb_top.sv
`timescale 1ns/1ps

`include "cpm_cfg.svh"

module tb_top
   import cpm_pkg::*;
   ;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic tsc_sync_i = 1'b0;
   cpm_req_t req_i;
   cpm_evt_t evt_i;
   logic req_ready_o;
   logic rsp_valid_o;
   cpm_rsp_t rsp_o;
   logic [7:0] ovf_o;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed = 6;
   int idx;
   int n;
   logic [63:0] r;
   logic [63:0] v [4];
   // expected answers, masks of checked bits, accept cycles
   cpm_rsp_t exp_q [$];
   logic [63:0] msk_q [$];
   int cyc_q [$];

   // 40 ns core clock
   always #20 clk_i = ~clk_i;

   cpm_core i_cpm_core (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .req_valid_i(req_valid_i),
      .req_i(req_i),
      .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o),
      .rsp_o(rsp_o),
      .evt_i(evt_i),
      .tsc_sync_i(tsc_sync_i),
      .ovf_o(ovf_o)
   );

   // ****************************************
   // verdict, compares and hang guard
   // ****************************************
   task end_sim;
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // latency 3 at the falling edge means sampled at the fourth edge
   task cmp_rsp(input cpm_rsp_t e, input cpm_rsp_t g,
                input logic [63:0] m, input int lat);
      cmp_count++;
      // ready must come back together with the answer pulse
      if (g.fault !== e.fault || (g.data & m) !== (e.data & m) ||
          lat != 3 || req_ready_o !== 1'b1) begin
         num_errors++;
         $display("unexpected answer at %0t: exp %h got %h lat %0d",
                  $time, e, g, lat);
      end
   endtask : cmp_rsp

   task cmp_ovf(input logic [7:0] e);
      cmp_count++;
      if (ovf_o !== e) begin
         num_errors++;
         $display("unexpected status at %0t: exp %h got %h", $time, e, ovf_o);
      end
   endtask : cmp_ovf

   // cycle count; ceiling far above the few hundred cycles needed
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         end_sim;
      end
   end

   // answer watcher: oldest note against each answer pulse
   always @(negedge clk_i) begin
      if (rsp_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("unexpected answer at %0t: exp none got %h",
                     $time, rsp_o);
         end else
            cmp_rsp(exp_q.pop_front(), rsp_o, msk_q.pop_front(),
                    cyc - cyc_q.pop_front());
      end
   end

   // ****************************************
   // request and event drivers
   // ****************************************
   // entered at a falling edge; holds the request across the accept edge
   task issue(input cpm_op_t op, input logic [1:0] t, input logic [1:0] pl,
              input logic m64, input logic [31:0] sel, input logic [63:0] wd,
              input logic f, input logic [63:0] ed, input logic [63:0] m);
      while (req_ready_o !== 1'b1)
         @(negedge clk_i);
      req_i = '{op, t, pl, m64, sel, wd};
      req_valid_i = 1'b1;
      @(negedge clk_i);
      req_valid_i = 1'b0;
      exp_q.push_back('{f, ed});
      msk_q.push_back(m);
      cyc_q.push_back(cyc);
   endtask : issue

   task rd(input logic [1:0] t, input logic [31:0] a, input logic [63:0] e);
      issue(OP_REG_RD, t, 2'h0, 1'b1, a, '0, 1'b0, e, '1);
   endtask : rd

   task wr(input logic [1:0] t, input logic [31:0] a, input logic [63:0] d);
      issue(OP_REG_WR, t, 2'h0, 1'b1, a, d, 1'b0, '0, '1);
   endtask : wr

   // faulting request: only the fault flag is checked
   task flt(input cpm_op_t op, input logic [1:0] pl, input logic m64,
            input logic [31:0] sel);
      issue(op, 2'h0, pl, m64, sel, '1, 1'b1, '0, '0);
   endtask : flt

   // one event line high for k edges; index 0-31 spans all four sources
   task ev(input int i, input logic [1:0] cx, input int k);
      cpm_evt_t e;
      e = '0;
      e.ctx = cx;
      case (i / 8)
         0: e.core[i % 8] = 1'b1;
         1: e.ring[i % 8] = 1'b1;
         2: e.tagdir[i % 8] = 1'b1;
         default: e.cri[i % 8] = 1'b1;
      endcase
      evt_i = e;
      repeat (k) @(negedge clk_i);
      evt_i = '0;
      // one quiet cycle keeps back-to-back calls apart
      @(negedge clk_i);
   endtask : ev

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      req_i = '0;
      evt_i = '0;
      repeat (8) @(negedge clk_i);
      rst_b_i = 1'b1;
      // reset values of every mapped register but the timestamp
      cmp_ovf(8'h00);
      rd(0, `CPM_A_CNT0, '0);
      rd(0, `CPM_A_CNT1, '0);
      rd(0, `CPM_A_SEL0, '0);
      rd(0, `CPM_A_SEL1, '0);
      rd(0, `CPM_A_UCTL, '0);
      rd(0, `CPM_A_OVST, '0);
      rd(0, `CPM_A_OVCL, '0);
      rd(0, `CPM_A_GEN, '0);
      // one counter copy per thread, 40 bits kept
      for (int t = 0; t < 4; t++) begin
         v[t] = {$random(seed), $random(seed)};
         wr(t[1:0], `CPM_A_CNT0, v[t]);
      end
      for (int t = 0; t < 4; t++)
         rd(t[1:0], `CPM_A_CNT0, {24'h0, v[t][39:0]});
      r = {$random(seed), $random(seed)};
      wr(1, `CPM_A_SEL1, r);
      rd(1, `CPM_A_SEL1, {32'h0, r[31:0]});
      wr(0, `CPM_A_UCTL, '1);
      rd(0, `CPM_A_UCTL, 64'h3);
      wr(0, `CPM_A_UCTL, '0);
      // refused requests leave state alone
      flt(OP_REG_RD, 2'h3, 1'b1, `CPM_A_CNT0);
      flt(OP_REG_WR, 2'h1, 1'b1, `CPM_A_CNT0);
      rd(0, `CPM_A_CNT0, {24'h0, v[0][39:0]});
      flt(OP_REG_RD, 2'h0, 1'b1, 32'h0000_0011);
      flt(OP_CNT_RD, 2'h3, 1'b1, 32'h0000_0002);
      flt(OP_UPREF, 2'h3, 1'b0, '0);
      wr(0, `CPM_A_OVST, '1);
      rd(0, `CPM_A_OVST, '0);
      // counting gated by global enable, from a random source line
      idx = {$random(seed)} % 32;
      n = {$random(seed)} % 8 + 1;
      wr(0, `CPM_A_CNT0, '0);
      wr(0, `CPM_A_SEL0, 32'h0040_0000 | idx);
      ev(idx, 2'h0, n);
      rd(0, `CPM_A_CNT0, '0);
      wr(0, `CPM_A_GEN, 64'h1);
      ev(idx, 2'h0, n);
      rd(0, `CPM_A_CNT0, 64'(n));
      issue(OP_CNT_RD, 0, 2'h3, 1'b1, `CPM_PMC_SEL0, '0, 1'b0,
            64'(n), '1);
      // context filter on core events: only context 2 counts
      wr(0, `CPM_A_SEL0, 32'h0440_0003);
      ev(3, 2'h1, 4);
      ev(3, 2'h2, 5);
      rd(0, `CPM_A_CNT0, 64'(n + 5));
      // preference gate: allowed but cleared stops counting
      wr(0, `CPM_A_UCTL, 64'h2);
      ev(3, 2'h2, 2);
      issue(OP_UPREF, 0, 2'h3, 1'b1, '0, 64'h1, 1'b0, '0, '0);
      ev(3, 2'h2, 2);
      rd(0, `CPM_A_CNT0, 64'(n + 7));
      rd(0, `CPM_A_UCTL, 64'h3);
      issue(OP_UPREF, 0, 2'h0, 1'b1, '0, 64'h0, 1'b0, '0, '0);
      rd(0, `CPM_A_UCTL, 64'h2);
      // wrap of counter 1 sets a sticky status bit; preference gate off
      wr(0, `CPM_A_UCTL, '0);
      wr(0, `CPM_A_CNT1, 64'h00FF_FFFF_FFFF);
      wr(0, `CPM_A_SEL1, 32'h0040_0008);
      wr(0, `CPM_A_GEN, 64'h3);
      ev(8, 2'h0, 1);
      cmp_ovf(8'h02);
      ev(8, 2'h0, 2);
      rd(0, `CPM_A_CNT1, 64'h2);
      rd(0, `CPM_A_OVST, 64'h2);
      wr(0, `CPM_A_OVCL, 64'h1);
      rd(0, `CPM_A_OVST, 64'h2);
      wr(0, `CPM_A_OVCL, 64'h2);
      rd(0, `CPM_A_OVST, '0);
      cmp_ovf(8'h00);
      // shared timestamp runs with counting off; back-to-back gives +3
      wr(0, `CPM_A_GEN, '0);
      r = {$random(seed), $random(seed)};
      wr(0, `CPM_A_TSC, r);
      issue(OP_TS_RD, 2, 2'h3, 1'b1, '0, '0, 1'b0, r + 3, '1);
      // sync pin restarts the timestamp near zero
      wr(0, `CPM_A_TSC, 64'hFFFF_0000_0000_0000);
      tsc_sync_i = 1'b1;
      repeat (6) @(negedge clk_i);
      tsc_sync_i = 1'b0;
      issue(OP_TS_RD, 0, 2'h0, 1'b1, '0, '0, 1'b0, '0, ~64'hFF);
      repeat (8) @(negedge clk_i);
      if (exp_q.size() != 0)
         num_errors++;
      end_sim;
   end

endmodule : tb_top
